// ==== logic/lpo_aux_decode.v ====
`default_nettype none
// Auxiliary mode and reference selection decode
module lpo_aux_decode (
  input wire [1:0] aux_osc_mode_in,
  input wire aux_ref_select_in,
  input wire ref_source_select_in,
  output reg aux_osc_enable_out,
  output reg aux_crystal_out,
  output reg aux_high_speed_out,
  output reg aux_external_out,
  output reg [1:0] ref_choice_out
);
`include "lpo_defs.vh"

  // Mode decode; every code has its own meaning
  always @* begin
    aux_crystal_out = 1'b0;
    aux_high_speed_out = 1'b0;
    aux_external_out = 1'b0;
    case (aux_osc_mode_in)
      `LPO_AUX_MODE_EC: aux_external_out = 1'b1;
      `LPO_AUX_MODE_XT: aux_crystal_out = 1'b1;
      `LPO_AUX_MODE_HS: aux_high_speed_out = 1'b1;
      default: aux_external_out = 1'b0;
    endcase
    aux_osc_enable_out = (aux_osc_mode_in != `LPO_AUX_MODE_OFF);
  end

  // Reference path: primary wins when both bits set
  always @* begin
    if (ref_source_select_in && aux_ref_select_in) begin
      ref_choice_out = `LPO_REF_PRIMARY;
    end else if (aux_ref_select_in) begin
      ref_choice_out = `LPO_REF_AUX_OSC;
    end else begin
      ref_choice_out = `LPO_REF_FAST_RC_PLL;
    end
  end
endmodule // lpo_aux_decode
`default_nettype wire

// ==== logic/lpo_defs.vh ====
`ifndef LPO_DEFS_VH
`define LPO_DEFS_VH
// Source codes for the current, next and initial source fields
`define LPO_SRC_FAST_RC 3'h0
`define LPO_SRC_FAST_RC_PLL 3'h1
`define LPO_SRC_PRIMARY 3'h2
`define LPO_SRC_PRIMARY_PLL 3'h3
`define LPO_SRC_SECONDARY 3'h4
`define LPO_SRC_LOW_POWER_RC 3'h5
// Oscillator control bit positions
`define LPO_CTRL_SWITCH_REQUEST 0
`define LPO_CTRL_SECONDARY_ALWAYS_ON 1
`define LPO_CTRL_PLL_LOCK 5
// Auxiliary clock control field positions
`define LPO_ACLK_MODE_HI 12
`define LPO_ACLK_MODE_LO 11
`define LPO_ACLK_REF_SELECT 12
`define LPO_ACLK_SOURCE_SELECT 13
// Auxiliary oscillator mode codes
`define LPO_AUX_MODE_OFF 2'h0
`define LPO_AUX_MODE_HS 2'h1
`define LPO_AUX_MODE_XT 2'h2
`define LPO_AUX_MODE_EC 2'h3
// Reference clock choices
`define LPO_REF_FAST_RC_PLL 2'h0
`define LPO_REF_AUX_OSC 2'h1
`define LPO_REF_PRIMARY 2'h2
// Reset values
`define LPO_ACLK_RESET 16'h0000
// PLL lock settle time in clock cycles
`define LPO_LOCK_CYCLES 8'h20
`endif

// ==== logic/lpo_lock_timer.v ====
`default_nettype none
// Models PLL settle: flag clears on restart, sets after a fixed count
module lpo_lock_timer (
  input wire sys_clk_in,
  input wire reset_in,
  input wire restart_in,
  input wire pll_selected_in,
  output reg locked_out
);
`include "lpo_defs.vh"

  reg [7:0] count;

  // Restart wins over completion so a fresh switch is never reported locked
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      count <= 8'h00;
      locked_out <= 1'b0;
    end else if (restart_in || !pll_selected_in) begin
      count <= 8'h00;
      locked_out <= 1'b0;
    end else if (count == `LPO_LOCK_CYCLES) begin
      locked_out <= 1'b1;
    end else begin
      count <= count + 8'h01;
    end
  end
endmodule // lpo_lock_timer
`default_nettype wire

// ==== logic/lpo_osc_enable.v ====
// Function
// - Secondary runs after reset when configured initial
// - Switch request to secondary enables it
// - Secondary off when unused or asleep
// - Always-on bit keeps secondary running
// - Sleep stops primary, fast and low-power RC
// - Low-power RC times timer, watchdog, monitor
// - Low-power RC as clock by config/switch
// - Low-power RC on at reset, kept past boot per timer config
// - Monitor, watchdog or selection keep low-power RC
// - Otherwise off after power-up timer expires
// - In sleep low-power RC only with watchdog
// - Low-power RC ready at once when enabled
// - Auxiliary mode field decode, reset disabled
// - Reference select bit picks auxiliary oscillator
// - Default reference is fast RC through PLL
// - Both bits select primary as reference
// - Read-only lock flag cleared on PLL switch
`default_nettype none
module lpo_osc_enable (
  input wire sys_clk_in,
  input wire reset_in,
  input wire [2:0] initial_source_cfg_in,
  input wire [2:0] power_up_time_cfg_in,
  input wire [2:0] next_source_in,
  input wire switch_request_in,
  input wire secondary_always_on_in,
  input wire [15:0] aux_clock_control_in,
  input wire aux_clock_control_write_in,
  input wire sleep_in,
  input wire watchdog_enable_in,
  input wire clock_fail_monitor_enable_in,
  input wire power_up_timer_expired_in,
  input wire source_ready_in,
  output reg [2:0] current_source_out,
  output wire switch_busy_out,
  output wire pll_lock_out,
  output reg secondary_osc_enable_out,
  output reg low_power_rc_osc_enable_out,
  output wire low_power_rc_osc_ready_out,
  output wire low_power_rc_timebase_out,
  output reg primary_osc_enable_out,
  output reg fast_rc_osc_enable_out,
  output wire pll_enable_out,
  output wire auxiliary_osc_enable_out,
  output wire aux_crystal_out,
  output wire aux_high_speed_out,
  output wire aux_external_out,
  output wire [1:0] aux_ref_choice_out
);
`include "lpo_defs.vh"

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Source codes that route through the PLL
  function is_pll;
    input [2:0] src;
    begin
      is_pll = (src == `LPO_SRC_FAST_RC_PLL) || (src == `LPO_SRC_PRIMARY_PLL);
    end
  endfunction

  // Source codes that use the primary oscillator
  function is_primary;
    input [2:0] src;
    begin
      is_primary = (src == `LPO_SRC_PRIMARY) || (src == `LPO_SRC_PRIMARY_PLL);
    end
  endfunction

  // Source codes that use the fast RC oscillator
  function is_fast_rc;
    input [2:0] src;
    begin
      is_fast_rc = (src == `LPO_SRC_FAST_RC) || (src == `LPO_SRC_FAST_RC_PLL);
    end
  endfunction

  // Source code of the secondary crystal
  function is_secondary;
    input [2:0] src;
    begin
      is_secondary = (src == `LPO_SRC_SECONDARY);
    end
  endfunction

  // Source code of the low-power RC
  function is_low_power_rc;
    input [2:0] src;
    begin
      is_low_power_rc = (src == `LPO_SRC_LOW_POWER_RC);
    end
  endfunction

  // A switch may end once the new source runs, and has locked if it goes through the PLL
  function switch_done;
    input [2:0] dest;
    input ready;
    input lock;
    begin
      switch_done = ready && (!is_pll(dest) || lock);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Switch sequencing state

  // Binary state codes; the unused code falls back to idle
  localparam ST_BOOT = 2'h0;
  localparam ST_IDLE = 2'h1;
  localparam ST_WAIT = 2'h2;

  // Sequencer registers and decode results
  reg [1:0] state;
  reg [1:0] next_state;
  reg [2:0] target;
  reg [2:0] next_target;
  reg [2:0] next_current;
  reg [15:0] aux_control;
  reg power_up_timer_window;
  reg lock_restart;
  reg next_secondary_enable;
  reg next_low_power_rc_enable;
  reg next_primary_enable;
  reg next_fast_rc_enable;
  wire locked;
  wire switching;
  wire request_valid;

  assign switching = (state == ST_WAIT);
  assign switch_busy_out = switching;

  // A request naming the source already running is redundant and dropped
  assign request_valid = switch_request_in && (next_source_in != current_source_out);

  // Next-state logic; redundant requests are dropped, PLL targets wait for lock.
  // Boot loads the configured source once; idle takes requests; wait holds the
  // old source until the new one is usable. Requests seen while busy are lost,
  // so software has to watch the busy flag before it asks again.
  always @* begin
    next_state = state;
    next_target = target;
    next_current = current_source_out;
    lock_restart = 1'b0;
    case (state)
      ST_BOOT: begin
        next_current = initial_source_cfg_in;
        next_target = initial_source_cfg_in;
        lock_restart = 1'b1;
        next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (request_valid) begin
          next_target = next_source_in;
          // Every accepted switch drops the flag: a PLL target then counts again,
          // any other target leaves it clear, so an old lock never outlives a switch
          lock_restart = 1'b1;
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Make before break: new source must be ready, and locked if PLL
        if (switch_done(target, source_ready_in, locked)) begin
          next_current = target;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // State registers
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      state <= ST_BOOT;
      target <= `LPO_SRC_FAST_RC;
      current_source_out <= `LPO_SRC_FAST_RC;
    end else begin
      state <= next_state;
      target <= next_target;
      current_source_out <= next_current;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL lock flag

  // Lock counter runs only while the target uses the PLL
  lpo_lock_timer u_lock (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .restart_in(lock_restart),
    .pll_selected_in(is_pll(target)),
    .locked_out(locked)
  );

  // Read-only: no write path, stays clear on non-PLL targets
  assign pll_lock_out = locked;
  // PLL runs while either end of a switch uses it
  assign pll_enable_out = is_pll(target) || is_pll(current_source_out);

  ////////////////////////////////////////////////////////////////////////////
  // Power-up window for the low-power RC

  // Window is set by reset and stays open past boot only when the timer value config is nonzero.
  // Expiry is a level from outside; the window never reopens without a reset
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      power_up_timer_window <= 1'b1;
    end else if (state == ST_BOOT) begin
      power_up_timer_window <= (power_up_time_cfg_in != 3'h0);
    end else if (power_up_timer_expired_in) begin
      power_up_timer_window <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator enables

  // Wanted levels look at where the source is headed as well as where it is,
  // so the new oscillator starts before the old one is dropped
  always @* begin
    next_secondary_enable = 1'b0;
    next_low_power_rc_enable = 1'b0;
    next_primary_enable = 1'b0;
    next_fast_rc_enable = 1'b0;
    if (sleep_in) begin
      // Sleep keeps only the always-on secondary and the watchdog time base
      next_secondary_enable = secondary_always_on_in;
      next_low_power_rc_enable = watchdog_enable_in;
    end else begin
      next_secondary_enable = secondary_always_on_in
        || is_secondary(next_current)
        || is_secondary(next_target);
      next_low_power_rc_enable = clock_fail_monitor_enable_in
        || watchdog_enable_in
        || is_low_power_rc(next_current)
        || is_low_power_rc(next_target)
        || power_up_timer_window;
      next_primary_enable = is_primary(next_current) || is_primary(next_target);
      // Fast RC also runs through boot, before the configured source is known
      next_fast_rc_enable = is_fast_rc(next_current) || is_fast_rc(next_target)
        || (state == ST_BOOT);
    end
  end

  // Enables are registered so the pins never glitch during decode
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      secondary_osc_enable_out <= 1'b0;
      low_power_rc_osc_enable_out <= 1'b1;
      primary_osc_enable_out <= 1'b0;
      fast_rc_osc_enable_out <= 1'b1;
    end else begin
      secondary_osc_enable_out <= next_secondary_enable;
      low_power_rc_osc_enable_out <= next_low_power_rc_enable;
      primary_osc_enable_out <= next_primary_enable;
      fast_rc_osc_enable_out <= next_fast_rc_enable;
    end
  end

  // No start-up delay: ready follows the enable directly
  assign low_power_rc_osc_ready_out = low_power_rc_osc_enable_out;
  // Time base offered to timer, watchdog and fail monitor
  assign low_power_rc_timebase_out = low_power_rc_osc_enable_out;

  ////////////////////////////////////////////////////////////////////////////
  // Auxiliary clock control

  // Held copy; reset gives disabled mode and fast RC via PLL reference.
  // Bit 12 is both the mode's upper bit and the reference select, so crystal
  // and external modes route the auxiliary oscillator to the reference unless bit 13 selects primary
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      aux_control <= `LPO_ACLK_RESET;
    end else if (aux_clock_control_write_in) begin
      aux_control <= aux_clock_control_in;
    end
  end

  // Decode of the held word into mode flags and reference choice
  lpo_aux_decode u_aux (
    .aux_osc_mode_in(aux_control[`LPO_ACLK_MODE_HI:`LPO_ACLK_MODE_LO]),
    .aux_ref_select_in(aux_control[`LPO_ACLK_REF_SELECT]),
    .ref_source_select_in(aux_control[`LPO_ACLK_SOURCE_SELECT]),
    .aux_osc_enable_out(auxiliary_osc_enable_out),
    .aux_crystal_out(aux_crystal_out),
    .aux_high_speed_out(aux_high_speed_out),
    .aux_external_out(aux_external_out),
    .ref_choice_out(aux_ref_choice_out)
  );

endmodule // lpo_osc_enable
`default_nettype wire

// ==== test/lpo_osc_checker.sv ====
`default_nettype none
// Port checks on the oscillator enables; enables follow their cause one cycle later
module lpo_osc_checker (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic secondary_always_on_in,
  input wire logic [15:0] aux_clock_control_in,
  input wire logic aux_clock_control_write_in,
  input wire logic sleep_in,
  input wire logic watchdog_enable_in,
  input wire logic switch_busy_out,
  input wire logic pll_lock_out,
  input wire logic secondary_osc_enable_out,
  input wire logic low_power_rc_osc_enable_out,
  input wire logic fast_rc_osc_enable_out,
  input wire logic auxiliary_osc_enable_out,
  input wire logic [1:0] aux_ref_choice_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // Sleep overrides the secondary, fast RC and low-power RC enables except the always-on bit and the watchdog
  property p_aon; secondary_always_on_in |=> secondary_osc_enable_out; endproperty
  a_aon: assert property (p_aon) else $error("secondary dropped");
  property p_sslp; sleep_in && !secondary_always_on_in |=> !secondary_osc_enable_out; endproperty
  a_sslp: assert property (p_sslp) else $error("secondary on in sleep");
  property p_fslp; sleep_in |=> !fast_rc_osc_enable_out; endproperty
  a_fslp: assert property (p_fslp) else $error("fast rc on in sleep");
  property p_lslp; sleep_in |=> low_power_rc_osc_enable_out == $past(watchdog_enable_in); endproperty
  a_lslp: assert property (p_lslp) else $error("low power rc wrong in sleep");
  property p_lwdt; !sleep_in && watchdog_enable_in |=> low_power_rc_osc_enable_out; endproperty
  a_lwdt: assert property (p_lwdt) else $error("low power rc off");
  // A stale lock must not survive into a new switch
  property p_lock; $rose(switch_busy_out) |-> !pll_lock_out; endproperty
  a_lock: assert property (p_lock) else $error("lock at switch start");
  property p_amod;
    aux_clock_control_write_in |=> auxiliary_osc_enable_out == |$past(aux_clock_control_in[12:11]);
  endproperty
  a_amod: assert property (p_amod) else $error("aux enable wrong");
  property p_aref;
    aux_clock_control_write_in && aux_clock_control_in[12] |=>
      aux_ref_choice_out == {$past(aux_clock_control_in[13]), !$past(aux_clock_control_in[13])};
  endproperty
  a_aref: assert property (p_aref) else $error("aux reference wrong");
  c_lock: cover property ($rose(pll_lock_out));
  c_wslp: cover property (sleep_in && watchdog_enable_in);
  c_aux: cover property (aux_clock_control_write_in && aux_clock_control_in[13]);
endmodule // lpo_osc_checker
////////////////////////////////////////////////////////////////////////
bind lpo_osc_enable lpo_osc_checker i_chk (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
  .secondary_always_on_in(secondary_always_on_in), .aux_clock_control_in(aux_clock_control_in),
  .aux_clock_control_write_in(aux_clock_control_write_in), .sleep_in(sleep_in),
  .watchdog_enable_in(watchdog_enable_in), .switch_busy_out(switch_busy_out), .pll_lock_out(pll_lock_out),
  .secondary_osc_enable_out(secondary_osc_enable_out), .low_power_rc_osc_enable_out(low_power_rc_osc_enable_out),
  .fast_rc_osc_enable_out(fast_rc_osc_enable_out), .auxiliary_osc_enable_out(auxiliary_osc_enable_out),
  .aux_ref_choice_out(aux_ref_choice_out));
`default_nettype wire

// ==== test/lpo_osc_enable_tb.sv ====
`default_nettype none
module lpo_osc_enable_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0, aon = 1'b0, awr = 1'b0, slp = 1'b0, wdt = 1'b0, mon = 1'b0, pdone = 1'b0;
  logic [2:0] nsrc = 3'h0;
  logic [15:0] aword = 16'h0000;
  logic [2:0] cur;
  logic busy, lock, sec, lp, lprdy, lptb, prim, fast_rc_osc, pll, aen, axt, ahs, aec;
  logic [1:0] refc;
  int bad_count = 0;
  int checks = 0;
  // Boots from the secondary with a power-up window; source always ready
  lpo_osc_enable i_dut (.sys_clk_in(clk), .reset_in(rst), .initial_source_cfg_in(3'h4), .power_up_time_cfg_in(3'h1),
    .next_source_in(nsrc), .switch_request_in(req), .secondary_always_on_in(aon), .aux_clock_control_in(aword),
    .aux_clock_control_write_in(awr), .sleep_in(slp), .watchdog_enable_in(wdt), .clock_fail_monitor_enable_in(mon),
    .power_up_timer_expired_in(pdone), .source_ready_in(1'b1), .current_source_out(cur), .switch_busy_out(busy),
    .pll_lock_out(lock), .secondary_osc_enable_out(sec), .low_power_rc_osc_enable_out(lp),
    .low_power_rc_osc_ready_out(lprdy), .low_power_rc_timebase_out(lptb), .primary_osc_enable_out(prim),
    .fast_rc_osc_enable_out(fast_rc_osc), .pll_enable_out(pll), .auxiliary_osc_enable_out(aen), .aux_crystal_out(axt),
    .aux_high_speed_out(ahs), .aux_external_out(aec), .aux_ref_choice_out(refc));
  // 40 ns clock
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Checks land at the falling edge, well clear of the launching edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // One-cycle request, then a bounded wait for busy to fall
  task automatic sw(input logic [2:0] src);
    int n;
    n = 0;
    @(posedge clk);
    nsrc <= src;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    while (busy !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("cur", {13'h0, src}, cur); // Switch done
  endtask
  task automatic aux(input logic [15:0] w);
    @(posedge clk);
    aword <= w;
    awr <= 1'b1;
    @(posedge clk);
    awr <= 1'b0;
    @(negedge clk);
  endtask
  task final_report;
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    step(5);
    chk("lp", 1'h1, lp); // Reset
    chk("aen", 1'h0, aen); // Reset
    chk("ref", 2'h0, refc); // Reset
    chk("lock", 1'h0, lock); // Reset
    @(posedge clk);
    rst <= 1'b0;
    step(3);
    chk("cur", 3'h4, cur); // Boot
    chk("sec", 1'h1, sec); // Boot
    chk("boot", 3'h0, {prim, fast_rc_osc, pll}); // Boot
    @(posedge clk);
    pdone <= 1'b1;
    step(3);
    chk("lp", 1'h0, lp); // Expiry
    @(posedge clk);
    wdt <= 1'b1;
    step(2);
    chk("lp", 3'h7, {lp, lprdy, lptb}); // Watchdog
    @(posedge clk);
    wdt <= 1'b0;
    mon <= 1'b1;
    step(2);
    chk("lp", 1'h1, lp); // Monitor
    @(posedge clk);
    mon <= 1'b0;
    sw(3'h3); // To PLL
    chk("lock", 1'h1, lock); // Locked
    chk("pll", 2'h3, {prim, pll}); // Primary with PLL
    step(2);
    chk("sec", 1'h0, sec); // Unused
    sw(3'h5); // To RC
    chk("lp", 2'h2, {lp, lock}); // RC
    chk("pll", 2'h0, {prim, pll}); // RC
    sw(3'h4); // Back
    chk("sec", 2'h2, {sec, lp}); // Back
    @(posedge clk);
    slp <= 1'b1;
    step(2);
    chk("slp", 4'h0, {sec, lp, prim, fast_rc_osc}); // Sleep
    @(posedge clk);
    wdt <= 1'b1;
    aon <= 1'b1;
    step(2);
    chk("slp", 2'h3, {sec, lp}); // Kept
    @(posedge clk);
    slp <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      aux(16'(i) << 11);
      chk("amod", {i == 3, i == 2, i == 1, i != 0}, {aec, axt, ahs, aen}); // Modes
      chk("ref", {1'b0, i > 1}, refc); // Aux
    end
    aux(16'h3000);
    chk("ref", 2'h2, refc); // Primary
    final_report();
  end
  // Hang guard, far beyond the roughly 80 cycles needed
  initial begin
    step(3000);
    bad_count++;
    final_report();
  end
endmodule // lpo_osc_enable_tb
`default_nettype wire
